// File: rtl/qtsp_pkg.sv
// Shared constants, modes and helpers for the quad transcoder serial port
package qtsp_pkg;

    localparam logic [4:0]  SLOT_BITS_COMPANDED = 5'h08;
    localparam logic [4:0]  SLOT_BITS_LINEAR    = 5'h10;
    localparam logic [7:0]  DC_SLOT_BITS        = 8'h10;
    localparam logic [8:0]  DLY_COMPANDED       = 9'h040;
    localparam logic [8:0]  DLY_LINEAR          = 9'h080;
    localparam logic [9:0]  SERIAL_IDLE_MAX     = 10'h3FF;
    localparam logic        SAMPLE_PHASE        = 1'b1;
    localparam logic        LAUNCH_PHASE        = 1'b0;
    localparam int          LANES               = 3;
    localparam int          LANE_W              = 16;
    localparam int          RX_WORD_W           = 1 + LANES * LANE_W;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_TELECOM,
        LINK_SERIAL
    } qtsp_link_t;

    // Order follows the three mode pins read as a binary number
    typedef enum logic [2:0] {
        ENC_32K,
        ENC_24K,
        ENC_16K,
        BYP_ADPCM,
        BYP_ADPCM_16K,
        BYP_PCM,
        ALG_RESET,
        COMP_OUT_OFF
    } qtsp_mode_t;

    // Active lanes in a B slot: {compressed, pcm port 2, pcm port 1}
    function automatic logic [2:0] lane_enable(input qtsp_mode_t mode,
                                               input logic       sel,
                                               input logic       b1,
                                               input logic       b2);
        logic [2:0] en;
        en = 3'h7;
        if (mode == BYP_PCM)
        begin
            en = sel ? 3'h2 : 3'h1;
        end
        else if (mode == ENC_16K || mode == BYP_ADPCM_16K)
        begin
            en[2] = sel ? b2 : b1;
        end
        return en;
    endfunction

endpackage

// File: rtl/qtsp_stream_if.sv
// Valid/ready word stream between the port logic and its buffer
`timescale 1ns/100ps
interface qtsp_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// File: rtl/qtsp_buf2.sv
// Two-entry buffer so a receiver stalled for up to two words loses none
`timescale 1ns/100ps
module qtsp_buf2 #(
    parameter int W = 8
) (
    input  wire logic     clock_in,
    input  wire logic     rst_in,
    qtsp_stream_if.snk    fill_if,
    qtsp_stream_if.src    drain_if
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wr;
        logic              rd;
        logic [1:0]        count;
    } qtsp_buf_state_t;

    qtsp_buf_state_t buf_reg;
    qtsp_buf_state_t buf_next;
    logic            push;
    logic            pop;

    assign fill_if.ready  = (buf_reg.count != 2'h2);
    assign drain_if.valid = (buf_reg.count != 2'h0);
    assign drain_if.data  = buf_reg.mem[buf_reg.rd];

    always_comb
    begin
        buf_next = buf_reg;
        push     = fill_if.valid && fill_if.ready;
        pop      = drain_if.valid && drain_if.ready;
        if (push)
        begin
            buf_next.mem[buf_reg.wr] = fill_if.data;
            buf_next.wr              = ~buf_reg.wr;
        end
        if (pop)
        begin
            buf_next.rd = ~buf_reg.rd;
        end
        case ({push, pop})
            2'b10:   buf_next.count = buf_reg.count + 2'h1;
            2'b01:   buf_next.count = buf_reg.count - 2'h1;
            default: buf_next.count = buf_reg.count;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            buf_reg <= '0;
        end
        else
        begin
            buf_reg <= buf_next;
        end
    end
endmodule

// File: rtl/qtsp_port.sv
// Serial PCM/compressed port logic of the quad voice transcoder
`timescale 1ns/100ps
module qtsp_port
    import qtsp_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    input  wire logic                 power_down_n_in,
    input  wire logic                 frame_pulse_in,
    input  wire logic                 serial_bit_clock_in,
    input  wire logic                 linear_in,
    input  wire logic                 port_select_in,
    input  wire logic                 enc_mode_bit0_in,
    input  wire logic                 enc_mode_bit1_in,
    input  wire logic                 enc_mode_bit2_in,
    input  wire logic                 b1_enable_in,
    input  wire logic                 b2_enable_or_delayed_frame_in,
    output logic                      b2_enable_or_delayed_frame_out,
    output logic                      b2_enable_or_delayed_frame_oe_out,
    input  wire logic                 pcm_in_port1_in,
    input  wire logic                 pcm_in_port2_in,
    input  wire logic                 compressed_in,
    output logic                      pcm_out_port1_out,
    output logic                      pcm_out_port1_oe_out,
    output logic                      pcm_out_port2_out,
    output logic                      pcm_out_port2_oe_out,
    output logic                      compressed_out,
    output logic                      compressed_oe_out,
    output logic                      half_rate_bit_clock_out,
    output logic                      half_rate_bit_clock_oe_out,
    output logic                      b1_strobe_out,
    output logic                      b1_strobe_oe_out,
    output logic                      b2_strobe_out,
    output logic                      b2_strobe_oe_out,
    input  wire logic [LANE_W-1:0]    tx_pcm1_in,
    input  wire logic [LANE_W-1:0]    tx_pcm2_in,
    input  wire logic [LANE_W-1:0]    tx_comp_in,
    output logic      [RX_WORD_W-1:0] rx_data_out,
    output logic                      rx_valid_out,
    input  wire logic                 rx_ready_in,
    output logic                      rx_overrun_out,
    output logic                      alg_reset_out,
    output logic                      link_telecom_out,
    output logic                      link_serial_out
);
    typedef struct packed {
        qtsp_link_t                 link;
        logic [9:0]                 idle;
        logic [8:0]                 cnt;
        logic                       fp_prev;
        logic                       bclk_prev;
        logic [4:0]                 pos;
        logic [LANES-1:0][LANE_W-1:0] rx;
        logic [LANES-1:0][LANE_W-1:0] tx;
        logic [LANES-1:0]           dout;
        logic [LANES-1:0]           oe;
        logic                       pv;
        logic [RX_WORD_W-1:0]       pw;
        logic                       overrun;
        logic                       alg_reset;
        logic                       bclk_o;
        logic                       s1;
        logic                       s2;
        logic                       s2_oe;
        logic                       dfr;
    } qtsp_state_t;

    qtsp_state_t               st_reg;
    qtsp_state_t               st_next;
    qtsp_mode_t                mode;
    logic                      telecom;
    logic                      in_b1;
    logic                      in_b2;
    logic                      in_dc;
    logic                      sample_ev;
    logic                      launch_ev;
    logic                      frame_start;
    logic                      word_done;
    logic [4:0]                pos;
    logic [7:0]                bitn;
    logic [7:0]                len8;
    logic [LANES-1:0]          act;
    logic [LANES-1:0]          din;
    logic [LANES-1:0][LANE_W-1:0] txw;

    qtsp_stream_if #(.W(RX_WORD_W)) fill_if ();
    qtsp_stream_if #(.W(RX_WORD_W)) drain_if ();

    assign mode        = qtsp_mode_t'({enc_mode_bit2_in, enc_mode_bit1_in, enc_mode_bit0_in});
    assign din         = {compressed_in, pcm_in_port2_in, pcm_in_port1_in};
    assign txw         = {tx_comp_in, tx_pcm2_in, tx_pcm1_in};
    assign len8        = {3'h0, linear_in ? SLOT_BITS_LINEAR : SLOT_BITS_COMPANDED};
    assign frame_start = st_reg.fp_prev && !frame_pulse_in;
    assign fill_if.data  = st_reg.pw;
    assign fill_if.valid = st_reg.pv;
    assign drain_if.ready = rx_ready_in;

    qtsp_buf2 #(.W(RX_WORD_W)) u_buf (
        .clock_in (clock_in),
        .rst_in   (rst_in || !power_down_n_in),
        .fill_if  (fill_if),
        .drain_if (drain_if)
    );

    always_comb
    begin
        st_next           = st_reg;
        st_next.fp_prev   = frame_pulse_in;
        st_next.bclk_prev = serial_bit_clock_in;
        if (frame_pulse_in)
        begin
            st_next.idle = '0;
            st_next.link = LINK_TELECOM;
        end
        else if (st_reg.idle != SERIAL_IDLE_MAX)
        begin
            st_next.idle = st_reg.idle + 10'h001;
        end
        else
        begin
            st_next.link = LINK_SERIAL;
        end
        telecom     = (st_next.link == LINK_TELECOM);
        st_next.cnt = frame_start ? 9'h000 : st_reg.cnt + 9'h001;
        bitn        = st_next.cnt[8:1];
        in_b1 = 1'b0;
        in_b2 = 1'b0;
        in_dc = 1'b0;
        pos   = st_reg.pos;
        sample_ev = 1'b0;
        launch_ev = 1'b0;
        if (telecom)
        begin
            in_b1 = bitn < len8;
            in_b2 = (bitn >= len8) && (bitn < {len8[6:0], 1'b0});
            in_dc = (bitn >= {len8[6:0], 1'b0}) && (bitn < {len8[6:0], 1'b0} + DC_SLOT_BITS);
            pos   = in_b1 ? bitn[4:0] : 5'(bitn - len8);
            sample_ev = (st_next.cnt[0] == SAMPLE_PHASE);
            launch_ev = (st_next.cnt[0] == LAUNCH_PHASE);
        end
        else if (st_next.link == LINK_SERIAL)
        begin
            in_b1 = b1_enable_in;
            in_b2 = b2_enable_or_delayed_frame_in;
            sample_ev = st_reg.bclk_prev && !serial_bit_clock_in;
            launch_ev = !st_reg.bclk_prev && serial_bit_clock_in;
        end
        if (!(in_b1 || in_b2))
        begin
            st_next.pos = 5'h00;
        end
        else if (sample_ev)
        begin
            st_next.pos = st_reg.pos + 5'h01;
        end
        // Mode pins are read live each bit, so rate changes need no restart
        act = (in_b1 || in_b2) ? lane_enable(mode, port_select_in, in_b1, in_b2) : 3'h0;
        for (int i = 0; i < LANES; i++)
        begin
            if (act[i] && sample_ev)
            begin
                st_next.rx[i] = {st_reg.rx[i][LANE_W-2:0], din[i]};
            end
            if (act[i] && launch_ev)
            begin
                st_next.dout[i] = (pos == 5'h00) ? txw[i][LANE_W-1] : st_reg.tx[i][LANE_W-1];
                st_next.tx[i]   = (pos == 5'h00) ? {txw[i][LANE_W-2:0], 1'b0}
                                                 : {st_reg.tx[i][LANE_W-2:0], 1'b0};
            end
        end
        st_next.oe    = act;
        st_next.oe[2] = act[2] && (mode != COMP_OUT_OFF);
        if (in_dc && !b1_enable_in)
        begin
            st_next.oe[1:0]   = 2'h3;
            st_next.dout[1:0] = din[1:0];
        end
        word_done = sample_ev && (in_b1 || in_b2) && ({3'h0, pos} == len8 - 8'h01);
        if (st_reg.pv && fill_if.ready)
        begin
            st_next.pv = 1'b0;
        end
        if (word_done)
        begin
            if (!st_next.pv)
            begin
                st_next.pv = 1'b1;
                st_next.pw = {in_b2, st_next.rx[2], st_next.rx[1], st_next.rx[0]};
            end
            else
            begin
                st_next.overrun = 1'b1;
            end
        end
        st_next.alg_reset = (mode == ALG_RESET);
        st_next.bclk_o = telecom && !st_next.cnt[0];
        st_next.s1     = telecom && (linear_in ? (bitn == 8'h00) : in_b1);
        st_next.s2     = telecom && in_b2;
        st_next.s2_oe  = telecom && !linear_in;
        st_next.dfr    = !(telecom && st_next.cnt[8:1] ==
                          (linear_in ? DLY_LINEAR[8:1] : DLY_COMPANDED[8:1]));
        if (!power_down_n_in)
        begin
            st_next = '0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign link_telecom_out     = (st_reg.link == LINK_TELECOM);
    assign link_serial_out      = (st_reg.link == LINK_SERIAL);
    assign half_rate_bit_clock_out    = st_reg.bclk_o;
    assign half_rate_bit_clock_oe_out = link_telecom_out;
    assign b1_strobe_out        = st_reg.s1;
    assign b1_strobe_oe_out     = link_telecom_out;
    assign b2_strobe_out        = st_reg.s2;
    assign b2_strobe_oe_out     = st_reg.s2_oe;
    assign b2_enable_or_delayed_frame_out    = st_reg.dfr;
    assign b2_enable_or_delayed_frame_oe_out = link_telecom_out;
    assign pcm_out_port1_out    = st_reg.dout[0];
    assign pcm_out_port1_oe_out = st_reg.oe[0];
    assign pcm_out_port2_out    = st_reg.dout[1];
    assign pcm_out_port2_oe_out = st_reg.oe[1];
    assign compressed_out       = st_reg.dout[2];
    assign compressed_oe_out    = st_reg.oe[2];
    assign rx_data_out          = drain_if.data;
    assign rx_valid_out         = drain_if.valid;
    assign rx_overrun_out       = st_reg.overrun;
    assign alg_reset_out        = st_reg.alg_reset;

    sequence s_tel_companded_start;
        frame_start && link_telecom_out && !linear_in && power_down_n_in;
    endsequence

    property p_bclk_float;
        @(posedge clock_in) disable iff (rst_in)
        link_serial_out |-> !half_rate_bit_clock_oe_out && !b1_strobe_oe_out;
    endproperty
    a_bclk_float: assert property (p_bclk_float) else $error("bit clock or strobe driven");

    property p_bclk_toggle;
        @(posedge clock_in) disable iff (rst_in)
        (link_telecom_out && power_down_n_in && !frame_start && frame_pulse_in)
            |=> (half_rate_bit_clock_out != $past(half_rate_bit_clock_out));
    endproperty
    a_bclk_toggle: assert property (p_bclk_toggle) else $error("bit clock not half rate");

    property p_b1_linear_pulse;
        @(posedge clock_in) disable iff (rst_in)
        ($rose(b1_strobe_out) && linear_in && power_down_n_in)
            |=> b1_strobe_out ##1 !b1_strobe_out;
    endproperty
    a_b1_linear_pulse: assert property (p_b1_linear_pulse) else $error("linear strobe width");

    property p_b1_companded;
        @(posedge clock_in) disable iff (rst_in)
        ($rose(b1_strobe_out) && !linear_in && power_down_n_in && frame_pulse_in)
            |-> b1_strobe_out[*8] ##1 b1_strobe_out[*8] ##1 !b1_strobe_out;
    endproperty
    a_b1_companded: assert property (p_b1_companded) else $error("B1 strobe not 8 bits");

    property p_delay_frame;
        @(posedge clock_in) disable iff (rst_in)
        s_tel_companded_start |-> ##65 (!b2_enable_or_delayed_frame_out || !power_down_n_in);
    endproperty
    a_delay_frame: assert property (p_delay_frame) else $error("delayed frame late");

    property p_b2_linear_float;
        @(posedge clock_in) disable iff (rst_in)
        linear_in |=> !b2_strobe_oe_out;
    endproperty
    a_b2_linear_float: assert property (p_b2_linear_float) else $error("B2 strobe driven");

    property p_power_down;
        @(posedge clock_in) disable iff (rst_in)
        !power_down_n_in |=> !(pcm_out_port1_oe_out || pcm_out_port2_oe_out || compressed_oe_out
                               || half_rate_bit_clock_oe_out || b2_enable_or_delayed_frame_oe_out);
    endproperty
    a_power_down: assert property (p_power_down) else $error("output driven in power-down");

    property p_dc_float;
        @(posedge clock_in) disable iff (rst_in)
        (telecom && in_dc && b1_enable_in && power_down_n_in) |=> !pcm_out_port1_oe_out;
    endproperty
    a_dc_float: assert property (p_dc_float) else $error("D/C slot driven");

    property p_bypass_port;
        @(posedge clock_in) disable iff (rst_in)
        (mode == BYP_PCM && port_select_in) |=> !pcm_out_port1_oe_out || $past(in_dc);
    endproperty
    a_bypass_port: assert property (p_bypass_port) else $error("bypass on wrong port");

    property p_16k_slot;
        @(posedge clock_in) disable iff (rst_in)
        (mode == ENC_16K && port_select_in && in_b1 && !in_b2) |=> !compressed_oe_out;
    endproperty
    a_16k_slot: assert property (p_16k_slot) else $error("16k word in B1 slot");
endmodule

// File: verif/qtsp_far_end.sv
// Far-end codec model: frame pulse, bit clock, slot strobes and serial data
`timescale 1ns/100ps
module qtsp_far_end
(
    input  wire logic clock_in,
    output logic      frame_pulse_out,
    output logic      bit_clock_out,
    output logic      b1_enable_out,
    output logic      b2_enable_out,
    output logic      pcm1_out,
    output logic      pcm2_out,
    output logic      comp_out,
    input  wire logic pcm1_in,
    input  wire logic pcm2_in,
    input  wire logic comp_in,
    input  wire logic pcm1_oe_in,
    input  wire logic pcm2_oe_in,
    input  wire logic comp_oe_in,
    input  wire logic clk2_in,
    input  wire logic clk2_oe_in,
    input  wire logic st1_in,
    input  wire logic st2_in,
    input  wire logic st2_oe_in,
    input  wire logic dfr_in,
    input  wire logic dfr_oe_in
);
    initial
    begin
        frame_pulse_out = 1'b1;
        bit_clock_out = 1'b0;
        {b1_enable_out, b2_enable_out} = 2'h0;
        {pcm1_out, pcm2_out, comp_out} = 3'h0;
    end

    // One 512-cycle bus frame; step k sees the state after the k-th edge past frame start
    task automatic tel_frame(input logic [7:0] din, input logic dc_off,
                             output logic [23:0] q1, output int st1,
                             output int st2, output int dly, output int clk_bad,
                             output logic [2:0] comp_oe);
        st1 = 0;
        st2 = 0;
        dly = 0;
        clk_bad = 0;
        comp_oe = 3'h0;
        @(negedge clock_in);
        frame_pulse_out = 1'b0;
        b1_enable_out = dc_off;
        for (int k = 0; k < 511; k++)
        begin
            @(negedge clock_in);
            if (k == 0)
                frame_pulse_out = 1'b1;
            if (k % 2 == 0 && k < 16)
                {pcm1_out, pcm2_out, comp_out} = {3{din[7 - k / 2]}};
            else if (k > 16)
                {pcm1_out, pcm2_out, comp_out} = ~{pcm1_out, pcm2_out, comp_out};
            if (k % 2 == 1 && k < 16)
                {q1[23 - k / 2], q1[15 - k / 2], q1[7 - k / 2]} = {comp_in, pcm2_in, pcm1_in};
            st1 += st1_in;
            st2 += (st2_in && st2_oe_in);
            if (!dfr_in && dfr_oe_in && dly == 0)
                dly = k;
            clk_bad += (clk2_in !== ~k[0] || clk2_oe_in !== 1'b1);
            if (k inside {[0:15]})
                comp_oe[0] |= comp_oe_in;
            if (k inside {[16:31]})
                comp_oe[1] |= comp_oe_in;
            if (k inside {[32:63]})
                comp_oe[2] |= pcm1_oe_in;
        end
    endtask

    task automatic ser_hold();
        frame_pulse_out = 1'b0;
        repeat (1100) @(negedge clock_in);
    endtask

    // One eight-bit strobed slot, bit clock 3 cycles high and 3 low
    task automatic ser_slot(input logic b2, input logic [7:0] din, output logic [23:0] q1,
                            output logic [2:0] oe_any);
        oe_any = 3'h0;
        b1_enable_out = !b2;
        b2_enable_out = b2;
        for (int n = 7; n >= 0; n--)
        begin
            bit_clock_out = 1'b1;
            {pcm1_out, pcm2_out, comp_out} = {3{din[n]}};
            repeat (3) @(negedge clock_in);
            {q1[16 + n], q1[8 + n], q1[n]} = {comp_in, pcm2_in, pcm1_in};
            oe_any |= {comp_oe_in, pcm2_oe_in, pcm1_oe_in};
            bit_clock_out = 1'b0;
            repeat (3) @(negedge clock_in);
        end
        {b1_enable_out, b2_enable_out} = 2'h0;
        {pcm1_out, pcm2_out, comp_out} = ~{pcm1_out, pcm2_out, comp_out};
        // One idle edge so the slot position restarts before the next strobe
        @(negedge clock_in);
    endtask
endmodule

// File: verif/qtsp_port_bench.sv
// Self-checking bench for the quad transcoder serial port logic
`timescale 1ns/100ps
module qtsp_port_bench
    import qtsp_pkg::*;
();
    localparam int TM[5] = '{0, 1, 2, 2, 7};
    localparam int TS[5] = '{0, 0, 1, 0, 0};
    localparam int TE[5] = '{7, 7, 6, 5, 0};
    localparam int SM[7] = '{5, 5, 2, 2, 2, 2, 7};
    localparam int SS[7] = '{0, 1, 1, 1, 0, 0, 0};
    localparam int SB[7] = '{0, 0, 0, 1, 0, 1, 0};
    localparam int SE[7] = '{1, 2, 3, 7, 7, 3, 3};
    logic                 clock_in, rst_in, power_down_n, linear, port_sel, rx_ready;
    logic [2:0]           enc_mode;
    logic [LANE_W-1:0]    tx_pcm1;
    logic                 frame, bclk, b1_en, b2_en, d1, d2, dc, b2_pin;
    logic                 b2_out, b2_oe, p1, p1_oe, p2, p2_oe, comp, comp_oe;
    logic                 clk2, clk2_oe, st1, st1_oe, st2, st2_oe;
    logic [RX_WORD_W-1:0] rx_data, w;
    logic                 rx_valid, overrun, alg_reset, link_tel, link_ser;
    logic [23:0]          q;
    logic [2:0]           oe;
    logic [2:0]           coe;
    int                   failures, total_checks, n1, n2, dly, cb;

    assign b2_pin = b2_oe ? b2_out : b2_en;

    qtsp_port i_dut (.clock_in(clock_in), .rst_in(rst_in), .power_down_n_in(power_down_n),
        .frame_pulse_in(frame), .serial_bit_clock_in(bclk), .linear_in(linear),
        .port_select_in(port_sel), .enc_mode_bit0_in(enc_mode[0]),
        .enc_mode_bit1_in(enc_mode[1]), .enc_mode_bit2_in(enc_mode[2]),
        .b1_enable_in(b1_en), .b2_enable_or_delayed_frame_in(b2_pin),
        .b2_enable_or_delayed_frame_out(b2_out), .b2_enable_or_delayed_frame_oe_out(b2_oe),
        .pcm_in_port1_in(d1), .pcm_in_port2_in(d2), .compressed_in(dc),
        .pcm_out_port1_out(p1), .pcm_out_port1_oe_out(p1_oe), .pcm_out_port2_out(p2),
        .pcm_out_port2_oe_out(p2_oe), .compressed_out(comp), .compressed_oe_out(comp_oe),
        .half_rate_bit_clock_out(clk2), .half_rate_bit_clock_oe_out(clk2_oe),
        .b1_strobe_out(st1), .b1_strobe_oe_out(st1_oe), .b2_strobe_out(st2),
        .b2_strobe_oe_out(st2_oe), .tx_pcm1_in(tx_pcm1), .tx_pcm2_in(16'h5A00),
        .tx_comp_in(16'h6900), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
        .rx_ready_in(rx_ready), .rx_overrun_out(overrun), .alg_reset_out(alg_reset),
        .link_telecom_out(link_tel), .link_serial_out(link_ser));

    qtsp_far_end i_far (.clock_in(clock_in), .frame_pulse_out(frame), .bit_clock_out(bclk),
        .b1_enable_out(b1_en), .b2_enable_out(b2_en), .pcm1_out(d1), .pcm2_out(d2),
        .comp_out(dc), .pcm1_in(p1), .pcm1_oe_in(p1_oe), .pcm2_in(p2), .pcm2_oe_in(p2_oe),
        .comp_in(comp), .comp_oe_in(comp_oe), .clk2_in(clk2), .clk2_oe_in(clk2_oe), .st1_in(st1),
        .st2_in(st2), .st2_oe_in(st2_oe), .dfr_in(b2_pin), .dfr_oe_in(b2_oe));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic rx_pop(output logic [RX_WORD_W-1:0] word);
        int t = 0;
        while (rx_valid !== 1'b1 && t < 100)
        begin
            @(negedge clock_in);
            t++;
        end
        check(rx_valid, 1'b1);
        word = rx_data;
        rx_ready = 1'b1;
        @(negedge clock_in);
        rx_ready = 1'b0;
        @(negedge clock_in);
    endtask

    // 25 MHz master clock
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    initial
    begin
        repeat (20000) @(posedge clock_in);
        failures++;
        results();
    end

    initial
    begin
        failures = 0;
        total_checks = 0;
        {rst_in, power_down_n, linear, port_sel, rx_ready} = 5'h18;
        enc_mode = 3'h0;
        tx_pcm1 = 16'hA500;
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        // Receiver stalls for five frames so the buffer fills and refuses
        for (int i = 0; i < 5; i++)
        begin
            enc_mode = TM[i][2:0];
            port_sel = TS[i][0];
            i_far.tel_frame(8'h96, i == 4, q, n1, n2, dly, cb, coe);
            check(link_tel, 1'b1);
            check(q[15:0], 16'h5AA5);
            check(n1, 16);
            check(n2, 16);
            check(dly, 64);
            check(cb, 0);
            check(coe, TE[i]);
        end
        check(overrun, 1'b1);
        check({rx_valid, rx_data[48], rx_data[7:0]}, {2'h2, 8'h96});
        linear = 1'b1;
        i_far.tel_frame(8'h96, 1'b0, q, n1, n2, dly, cb, coe);
        check(n1, 2);
        check(n2, 0);
        check(dly, 128);
        power_down_n = 1'b0;
        repeat (2) @(negedge clock_in);
        check({b2_oe, p1_oe, p2_oe, comp_oe, clk2_oe, st1_oe, st2_oe, link_tel}, 8'h00);
        check({rx_valid, overrun}, 2'h0);
        {power_down_n, linear, enc_mode} = 5'h10;
        i_far.ser_hold();
        check({link_ser, clk2_oe, st1_oe, st2_oe}, 4'h8);
        tx_pcm1 = 16'hC300;
        i_far.ser_slot(1'b0, 8'h3C, q, oe);
        check({q, oe}, {24'h695AC3, 3'h7});
        i_far.ser_slot(1'b1, 8'h5A, q, oe);
        check({q, oe}, {24'h695AC3, 3'h7});
        rx_pop(w);
        check({w[48], w[39:32], w[23:16], w[7:0]}, {1'b0, 24'h3C3C3C});
        rx_pop(w);
        check({w[48], w[7:0]}, {1'b1, 8'h5A});
        repeat (2) @(negedge clock_in);
        check(rx_valid, 1'b0);
        rx_ready = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            enc_mode = SM[i][2:0];
            port_sel = SS[i][0];
            i_far.ser_slot(SB[i][0], 8'hE1, q, oe);
            check(oe, SE[i]);
        end
        for (int m = 0; m < 8; m++)
        begin
            enc_mode = m[2:0];
            repeat (2) @(negedge clock_in);
            check(alg_reset, (m == 6));
        end
        results();
    end
endmodule
